// ==== test/flash_write_protection_logic_test.sv ====
`timescale 1ns/1ps
`default_nettype none
module flash_write_protection_logic_test;
  localparam int unsigned AXI_AW = 8;
  localparam int unsigned ADDR_W = 25;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [2:0] s_axi_awprot = 3'h0, s_axi_arprot = 3'h0;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, wp_level = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp, core_dq_o, core_dq_i, rsp;
  logic [31:0] s_axi_rdata, rd;
  logic data_line_third_i, data_line_third_o, data_line_third_oe;
  logic data_line_fourth_i, data_line_fourth_o, data_line_fourth_oe;
  logic core_dq_oe, write_protect_n, hold_reset_n, quad_mode, array_op_valid;
  logic [7:0] array_op_code;
  logic [24:0] array_op_addr;
  logic [3:0] c;
  int errors = 0, n_tests = 0, grants = 0, exp_grants = 0, n, tot, sh;
  logic [7:0] pe_ops [13] = '{8'h02, 8'h12, 8'h32, 8'h38, 8'h34, 8'h3E, 8'hD7,
    8'h20, 8'h21, 8'h52, 8'h5C, 8'hD8, 8'hDC};

  fwp_top #(.AXI_AW(AXI_AW), .ADDR_W(ADDR_W)) u_fwp_top (.*);
  fwp_pin_model u_fwp_pin_model (.aclk(aclk), .quad_mode(quad_mode),
    .third_oe(data_line_third_oe), .third_o(data_line_third_o),
    .fourth_oe(data_line_fourth_oe), .fourth_o(data_line_fourth_o), .wp_level(wp_level),
    .third_i(data_line_third_i), .fourth_i(data_line_fourth_i),
    .core_dq_o(core_dq_o), .core_dq_oe(core_dq_oe));

  initial begin
    forever #5 aclk = ~aclk;
  end
  always @(posedge aclk) begin
    if (array_op_valid === 1'b1) grants <= grants + 1;
  end

  task automatic stop_test();
    $display("errors=%0d n_tests=%0d", errors, n_tests);
    if (errors == 0 && n_tests > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_tests++;
    if (g !== e) begin
      errors++;
      $display("unexpected at %0t: got %h expected %h", $time, g, e);
    end
  endtask

  task automatic axw(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    logic aw_ok, w_ok;
    aw_ok = 1'b0;
    w_ok = 1'b0;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    while (!(aw_ok && w_ok)) begin
      @(posedge aclk);
      if (!aw_ok && s_axi_awready === 1'b1) begin
        aw_ok = 1'b1;
        s_axi_awvalid <= 1'b0;
      end
      if (!w_ok && s_axi_wready === 1'b1) begin
        w_ok = 1'b1;
        s_axi_wvalid <= 1'b0;
      end
    end
    // Late ready so the response must stand
    repeat (2) @(posedge aclk);
    s_axi_bready <= 1'b1;
    do @(posedge aclk); while (s_axi_bvalid !== 1'b1);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask

  task automatic axr(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do @(posedge aclk); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    @(posedge aclk);
    s_axi_rready <= 1'b1;
    do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask

  task automatic cmd(input logic [7:0] op, input logic [7:0] dat, input logic [3:0] res);
    axw(fwp_pkg::OFF_CMD, {16'h0000, dat, op}, rsp);
    axr(fwp_pkg::OFF_RESULT, rd, rsp);
    chk({20'h0, rd[15:8], rd[3:0]}, {20'h0, op, res});
  endtask

  task automatic prog(input logic [24:0] a, input logic [3:0] res, input logic [7:0] op);
    cmd(fwp_pkg::OP_WR_EN, 8'h00, 4'h1);
    axw(fwp_pkg::OFF_ADDR, {7'h0, a}, rsp);
    cmd(op, 8'h00, res);
    if (res == 4'h1) begin
      exp_grants++;
      chk({7'h0, array_op_addr}, {7'h0, a});
      chk({24'h0, array_op_code}, {24'h0, op});
    end
  endtask

  // Blocks protected per code, counted from the selected end
  function automatic int blocks(input logic big, input logic [3:0] k);
    if (k == 4'h0) return 0;
    if (big) return k[3] ? 128 : (1 << (k - 4'h1));
    if (k < 4'hA) return 1 << (k - 4'h1);
    case (k)
      4'hA: return 384;
      4'hB: return 448;
      4'hC: return 480;
      4'hD: return 496;
      4'hE: return 504;
      default: return 512;
    endcase
  endfunction

  initial begin
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    axw(fwp_pkg::OFF_STATUS, 32'h0000_00FC, rsp);
    chk({30'h0, rsp}, {30'h0, fwp_pkg::RESP_OKAY});
    axr(fwp_pkg::OFF_STATUS, rd, rsp);
    chk(rd, 32'h0);
    axr(8'h40, rd, rsp);
    chk({30'h0, rsp}, {30'h0, fwp_pkg::RESP_SLVERR});
    axw(8'h40, 32'h0000_0000, rsp);
    chk({30'h0, rsp}, {30'h0, fwp_pkg::RESP_SLVERR});
    cmd(fwp_pkg::OP_RDP_V_FREE, 8'h5A, 4'h1);
    axr(fwp_pkg::OFF_RDPARAM, rd, rsp);
    chk(rd, 32'h5A);
    cmd(fwp_pkg::OP_BANK_V_FREE, 8'h3C, 4'h1);
    axr(fwp_pkg::OFF_BANK, rd, rsp);
    chk(rd, 32'h3C);
    cmd(fwp_pkg::OP_RDP_V, 8'h11, 4'h2);
    cmd(fwp_pkg::OP_WR_EN, 8'h00, 4'h1);
    cmd(fwp_pkg::OP_BANK_V, 8'h77, 4'h1);
    axr(fwp_pkg::OFF_BANK, rd, rsp);
    chk(rd, 32'h77);
    cmd(fwp_pkg::OP_WR_EN, 8'h00, 4'h1);
    cmd(fwp_pkg::OP_WRDI, 8'h00, 4'h1);
    cmd(fwp_pkg::OP_RDP_V, 8'h22, 4'h2);
    axr(fwp_pkg::OFF_RDPARAM, rd, rsp);
    chk(rd, 32'h5A);
    cmd(8'hFF, 8'h00, 4'h5);
    // Area select sticks once set, so top area runs first
    for (int s = 0; s < 4; s++) begin
      axw(fwp_pkg::OFF_CONFIG, {30'h0, s[0], s[1]}, rsp);
      for (int k = 0; k < 16; k++) begin
        c = k[3:0];
        tot = s[0] ? 128 : 512;
        sh = s[0] ? 18 : 16;
        n = blocks(s[0], c);
        cmd(fwp_pkg::OP_WR_EN, 8'h00, 4'h1);
        cmd(fwp_pkg::OP_STATUS_WR, {2'b00, c, 2'b00}, 4'h1);
        axr(fwp_pkg::OFF_STATUS, rd, rsp);
        chk(rd, {26'h0, c, 2'b00});
        if (n > 0) prog(25'((s[1] ? n - 1 : tot - n) << sh), 4'h3, pe_ops[k % 13]);
        if (n < tot) prog(25'((((s[1] ? n : tot - n - 1) + 1) << sh) - 1), 4'h1,
          pe_ops[(k + 1) % 13]);
        cmd(fwp_pkg::OP_WR_EN, 8'h00, 4'h1);
        cmd(c[0] ? fwp_pkg::OP_ERASE_ALL_B : fwp_pkg::OP_ERASE_ALL_A, 8'h00,
          (c == 0) ? 4'h1 : 4'h3);
        if (c == 4'h0) exp_grants++;
      end
    end
    cmd(fwp_pkg::OP_WR_EN, 8'h00, 4'h1);
    cmd(fwp_pkg::OP_STATUS_WR, 8'h84, 4'h1);
    cmd(fwp_pkg::OP_WR_EN, 8'h00, 4'h1);
    cmd(fwp_pkg::OP_STATUS_WR, 8'h00, 4'h4);
    axr(fwp_pkg::OFF_STATUS, rd, rsp);
    chk(rd, 32'h86);
    wp_level <= 1'b1;
    repeat (3) @(posedge aclk);
    cmd(fwp_pkg::OP_STATUS_WR, 8'h40, 4'h1);
    axr(fwp_pkg::OFF_STATUS, rd, rsp);
    chk(rd, 32'h40);
    wp_level <= 1'b0;
    repeat (40) @(posedge aclk);
    chk({29'h0, quad_mode, write_protect_n, hold_reset_n}, 32'h7);
    cmd(fwp_pkg::OP_WR_EN, 8'h00, 4'h1);
    cmd(fwp_pkg::OP_STATUS_WR, 8'h00, 4'h1);
    repeat (3) @(posedge aclk);
    chk({29'h0, quad_mode, write_protect_n, hold_reset_n}, 32'h1);
    chk(grants, exp_grants);
    stop_test();
  end

  initial begin
    #500000;
    errors++;
    stop_test();
  end
endmodule // flash_write_protection_logic_test
`default_nettype wire

// ==== test/fwp_pin_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module fwp_pin_model (
  // Clock
  input wire logic aclk,
  // Device side
  input wire logic quad_mode,
  input wire logic third_oe,
  input wire logic third_o,
  input wire logic fourth_oe,
  input wire logic fourth_o,
  input wire logic wp_level,
  // Pin levels and core
  output logic third_i,
  output logic fourth_i,
  output logic [1:0] core_dq_o,
  output logic core_dq_oe
);
  logic [3:0] pat_ff = 4'h0;
  always_ff @(posedge aclk) begin
    pat_ff <= pat_ff + 4'h1;
  end
  // Pins driven by a live party, never tied to supply, so quad may be set
  // Released lines toggle in quad mode so a stale level cannot pass as data
  assign third_i = third_oe ? third_o : (quad_mode ? pat_ff[0] : wp_level);
  // Hold level moves opposite to the protect level so its pass-through is exercised
  assign fourth_i = fourth_oe ? fourth_o : (quad_mode ? ~pat_ff[0] : ~wp_level);
  assign core_dq_o = pat_ff[2:1];
  assign core_dq_oe = pat_ff[3];
endmodule // fwp_pin_model
`default_nettype wire

// ==== test/fwp_top_asserts.sv ====
`timescale 1ns/1ps
`default_nettype none
module fwp_top_asserts #(
  parameter int unsigned AXI_AW = 8,
  parameter int unsigned ADDR_W = 25
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Bus handshakes
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Pins and core
  input wire logic data_line_third_i,
  input wire logic data_line_third_o,
  input wire logic data_line_third_oe,
  input wire logic data_line_fourth_i,
  input wire logic data_line_fourth_o,
  input wire logic data_line_fourth_oe,
  input wire logic [1:0] core_dq_o,
  input wire logic core_dq_oe,
  input wire logic [1:0] core_dq_i,
  input wire logic write_protect_n,
  input wire logic hold_reset_n,
  input wire logic quad_mode,
  input wire logic array_op_valid
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  property p_pin_func;
    $past(aresetn) && !$past(quad_mode) |-> write_protect_n == $past(data_line_third_i)
      && hold_reset_n == $past(data_line_fourth_i);
  endproperty
  a_pin_func: assert property (p_pin_func)
    else $error("protect or hold pin not passed through");
  property p_oe_off;
    $past(aresetn) && !$past(quad_mode) |-> !data_line_third_oe && !data_line_fourth_oe;
  endproperty
  a_oe_off: assert property (p_oe_off)
    else $error("shared pin driven while quad off");
  property p_quad_out;
    $past(aresetn) && $past(quad_mode) |-> write_protect_n && hold_reset_n
      && {data_line_fourth_o, data_line_third_o} == $past(core_dq_o)
      && data_line_third_oe == $past(core_dq_oe) && data_line_fourth_oe == $past(core_dq_oe);
  endproperty
  a_quad_out: assert property (p_quad_out)
    else $error("quad output path wrong");
  property p_quad_in;
    $past(aresetn) && $past(quad_mode)
      |-> core_dq_i == $past({data_line_fourth_i, data_line_third_i});
  endproperty
  a_quad_in: assert property (p_quad_in)
    else $error("quad input path wrong");
  property p_grant;
    array_op_valid |-> s_axi_bvalid ##1 !array_op_valid;
  endproperty
  a_grant: assert property (p_grant)
    else $error("grant pulse outside its write");
  property p_w_answer;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |=> !s_axi_bvalid ##1 s_axi_bvalid;
  endproperty
  a_w_answer: assert property (p_w_answer)
    else $error("write response late or early");
  property p_b_hold;
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
  endproperty
  a_b_hold: assert property (p_b_hold)
    else $error("write response dropped");
  property p_r_answer;
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
  endproperty
  a_r_answer: assert property (p_r_answer)
    else $error("read data late");
  property p_r_hold;
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
  endproperty
  a_r_hold: assert property (p_r_hold)
    else $error("read data dropped");
  property p_busy;
    s_axi_bvalid |-> !s_axi_awready && !s_axi_wready;
  endproperty
  a_busy: assert property (p_busy)
    else $error("write taken during response");
endmodule // fwp_top_asserts

bind fwp_top fwp_top_asserts #(.AXI_AW(AXI_AW), .ADDR_W(ADDR_W)) u_fwp_top_asserts (.*);
`default_nettype wire

// ==== verilog/fwp_pkg.sv ====
`default_nettype none
package fwp_pkg;
  // Register byte offsets
  localparam logic [7:0] OFF_STATUS = 8'h00;
  localparam logic [7:0] OFF_CONFIG = 8'h04;
  localparam logic [7:0] OFF_CMD = 8'h08;
  localparam logic [7:0] OFF_ADDR = 8'h0C;
  localparam logic [7:0] OFF_RESULT = 8'h10;
  localparam logic [7:0] OFF_RDPARAM = 8'h14;
  localparam logic [7:0] OFF_BANK = 8'h18;

  // Status byte fields
  localparam int unsigned ST_WEL = 1;
  localparam int unsigned ST_PL_LO = 2;
  localparam int unsigned ST_QUAD = 6;
  localparam int unsigned ST_LOCK = 7;
  localparam logic [7:0] STATUS_RST = 8'h00;

  // Config fields
  localparam int unsigned CFG_AREA = 0;
  localparam int unsigned CFG_BIG = 1;

  // Command register fields
  localparam int unsigned CMD_OP_LO = 0;
  localparam int unsigned CMD_DAT_LO = 8;

  // Result register fields
  localparam int unsigned RES_CODE_LO = 0;
  localparam int unsigned RES_OP_LO = 8;

  // Opcodes
  localparam logic [7:0] OP_WR_EN = 8'h06;
  localparam logic [7:0] OP_WRDI = 8'h04;
  localparam logic [7:0] OP_STATUS_WR = 8'h01;
  localparam logic [7:0] OP_ERASE_ALL_A = 8'hC7;
  localparam logic [7:0] OP_ERASE_ALL_B = 8'h60;
  localparam logic [7:0] OP_RDP_V_FREE = 8'hC0;
  localparam logic [7:0] OP_RDP_V = 8'h63;
  localparam logic [7:0] OP_BANK_V_FREE = 8'h17;
  localparam logic [7:0] OP_BANK_V = 8'hC5;

  // Block geometry
  localparam int unsigned BLK64_SHIFT = 16;
  localparam int unsigned BLK256_SHIFT = 18;
  localparam logic [9:0] BLK64_TOTAL = 10'h200;
  localparam logic [9:0] BLK256_TOTAL = 10'h080;
  localparam logic [9:0] CNT_C10 = 10'h180;
  localparam logic [9:0] CNT_C11 = 10'h1C0;
  localparam logic [9:0] CNT_C12 = 10'h1E0;
  localparam logic [9:0] CNT_C13 = 10'h1F0;
  localparam logic [9:0] CNT_C14 = 10'h1F8;

  // AXI responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [3:0] {
    FWP_RES_NONE = 4'h0,
    FWP_RES_ACCEPT = 4'h1,
    FWP_RES_NO_WEL = 4'h2,
    FWP_RES_PROTECTED = 4'h3,
    FWP_RES_LOCKED = 4'h4,
    FWP_RES_UNKNOWN = 4'h5
  } fwp_result_t;
endpackage
`default_nettype wire

// ==== verilog/fwp_prot_decode.sv ====
`timescale 1ns/1ps
`default_nettype none
module fwp_prot_decode #(
  parameter int unsigned ADDR_W = 25
) (
  // Protection setting
  input wire logic [3:0] code,
  input wire logic area_bottom,
  input wire logic big_blocks,
  // Target
  input wire logic [ADDR_W-1:0] addr,
  output logic hit
);
  logic [9:0] blk;
  logic [9:0] total;
  logic [9:0] count;
  logic [ADDR_W-1:0] shifted;

  always_comb begin
    total = big_blocks ? fwp_pkg::BLK256_TOTAL : fwp_pkg::BLK64_TOTAL;
    shifted = big_blocks ? (addr >> fwp_pkg::BLK256_SHIFT) : (addr >> fwp_pkg::BLK64_SHIFT);
    blk = shifted[9:0];
    count = 10'h000;
    if (code == 4'h0) begin
      count = 10'h000;
    end else if (big_blocks) begin
      count = code[3] ? fwp_pkg::BLK256_TOTAL : (10'h001 << (code - 4'h1));
    end else begin
      unique case (code)
        4'hA: count = fwp_pkg::CNT_C10;
        4'hB: count = fwp_pkg::CNT_C11;
        4'hC: count = fwp_pkg::CNT_C12;
        4'hD: count = fwp_pkg::CNT_C13;
        4'hE: count = fwp_pkg::CNT_C14;
        4'hF: count = fwp_pkg::BLK64_TOTAL;
        default: count = 10'h001 << (code - 4'h1);
      endcase
    end
    // Bottom run starts at block 0, top run ends at the last block
    if (area_bottom) begin
      hit = (count != 10'h000) && (blk < count);
    end else begin
      hit = (count != 10'h000) && (blk >= (total - count));
    end
  end
endmodule // fwp_prot_decode
`default_nettype wire

// ==== verilog/fwp_top.sv ====
// Overview of operation
// - C0h and 17h writes need no write enable
// - Four level bits form one protection code
// - Program or erase into protected run inhibited
// - Whole-array erase only when code is zero
// - Lock bit clear: status writable whenever write enable is set
// - Lock set, pin low: status writes ignored
// - Lock set, pin high: status write allowed
// - Quad off: pins are protect and hold
// - Quad on: pins are data lines three, four
// - 64KB codes 1-9 protect powers of two
// - 64KB codes 10-15 large runs, 0 none
// - Area select zero top, one bottom
// - 256KB codes 1-7 protect powers of two
// - 256KB top code bit protects all blocks
// - Level, quad and lock bits written only by opcode 01h
`timescale 1ns/1ps
`default_nettype none
module fwp_top #(
  parameter int unsigned AXI_AW = 8,
  parameter int unsigned ADDR_W = 25
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite write address
  input wire logic [AXI_AW-1:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // AXI4-Lite write data
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read address
  input wire logic [AXI_AW-1:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  // AXI4-Lite read data
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Shared pins
  input wire logic data_line_third_i,
  output logic data_line_third_o,
  output logic data_line_third_oe,
  input wire logic data_line_fourth_i,
  output logic data_line_fourth_o,
  output logic data_line_fourth_oe,
  // Quad data path, protect, hold and quad mode toward the serial core
  input wire logic [1:0] core_dq_o,
  input wire logic core_dq_oe,
  output logic [1:0] core_dq_i,
  output logic write_protect_n,
  output logic hold_reset_n,
  output logic quad_mode,
  // Granted program or erase toward the array
  output logic array_op_valid,
  output logic [7:0] array_op_code,
  output logic [ADDR_W-1:0] array_op_addr
);
  logic aw_held_ff;
  logic w_held_ff;
  logic [AXI_AW-1:0] awaddr_ff;
  logic [31:0] wdata_ff;
  logic [3:0] wstrb_ff;
  logic bvalid_ff;
  logic [1:0] bresp_ff;
  logic rvalid_ff;
  logic [1:0] rresp_ff;
  logic [31:0] rdata_ff;
  logic [7:0] status_ff;
  logic [1:0] config_ff;
  logic [ADDR_W-1:0] addr_ff;
  logic [15:0] result_ff;
  logic [7:0] rdparam_ff;
  logic [7:0] bank_ff;
  logic wp_level_ff;
  logic hold_level_ff;
  logic [1:0] dq_in_ff;
  logic [1:0] dq_out_ff;
  logic dq_oe_ff;
  logic op_valid_ff;
  logic [7:0] op_code_ff;
  logic [ADDR_W-1:0] op_addr_ff;

  logic wr_go;
  logic wr_mapped;
  logic [5:0] wr_word;
  logic [5:0] rd_word;
  logic cmd_fire;
  logic [7:0] cmd_op;
  logic [7:0] cmd_dat;
  logic prot_hit;
  logic [3:0] level_code;
  logic [7:0] nxt_status;
  logic [7:0] nxt_rdparam;
  logic [7:0] nxt_bank;
  fwp_pkg::fwp_result_t res;
  logic grant;
  logic [31:0] nxt_rdata;
  logic nxt_rmapped;

  function automatic logic is_prog_erase(input logic [7:0] op);
    unique case (op)
      8'h02, 8'h12, 8'h32, 8'h38, 8'h34, 8'h3E, 8'hD7, 8'h20, 8'h21,
      8'h52, 8'h5C, 8'hD8, 8'hDC: is_prog_erase = 1'b1;
      default: is_prog_erase = 1'b0;
    endcase
  endfunction

  assign level_code = status_ff[fwp_pkg::ST_PL_LO +: 4];

  // AXI write channel: address and data taken in either order
  assign s_axi_awready = !aw_held_ff && !bvalid_ff;
  assign s_axi_wready = !w_held_ff && !bvalid_ff;
  assign wr_go = aw_held_ff && w_held_ff && !bvalid_ff;
  assign wr_word = awaddr_ff[7:2];
  assign s_axi_bvalid = bvalid_ff;
  assign s_axi_bresp = bresp_ff;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_ff <= 1'b0;
      awaddr_ff <= '0;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_held_ff <= 1'b1;
      awaddr_ff <= s_axi_awaddr;
    end else if (wr_go) begin
      aw_held_ff <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_held_ff <= 1'b0;
      wdata_ff <= 32'h0000_0000;
      wstrb_ff <= 4'h0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_held_ff <= 1'b1;
      wdata_ff <= s_axi_wdata;
      wstrb_ff <= s_axi_wstrb;
    end else if (wr_go) begin
      w_held_ff <= 1'b0;
    end
  end

  always_comb begin
    unique case ({wr_word, 2'b00})
      fwp_pkg::OFF_STATUS, fwp_pkg::OFF_CONFIG, fwp_pkg::OFF_CMD, fwp_pkg::OFF_ADDR,
      fwp_pkg::OFF_RESULT, fwp_pkg::OFF_RDPARAM, fwp_pkg::OFF_BANK: wr_mapped = 1'b1;
      default: wr_mapped = 1'b0;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_ff <= 1'b0;
      bresp_ff <= fwp_pkg::RESP_OKAY;
    end else if (wr_go) begin
      bvalid_ff <= 1'b1;
      bresp_ff <= wr_mapped ? fwp_pkg::RESP_OKAY : fwp_pkg::RESP_SLVERR;
    end else if (s_axi_bready) begin
      bvalid_ff <= 1'b0;
    end
  end

  // Config: area select is one-time, once bottom it stays bottom
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      config_ff <= 2'h0;
    end else if (wr_go && ({wr_word, 2'b00} == fwp_pkg::OFF_CONFIG) && wstrb_ff[0]) begin
      config_ff[fwp_pkg::CFG_AREA] <= config_ff[fwp_pkg::CFG_AREA] | wdata_ff[fwp_pkg::CFG_AREA];
      config_ff[fwp_pkg::CFG_BIG] <= wdata_ff[fwp_pkg::CFG_BIG];
    end
  end

  // Target address, byte lanes honoured
  for (genvar b = 0; b < 4; b++) begin : g_addr_lane
    localparam int unsigned HI = ((b * 8 + 7) < ADDR_W) ? (b * 8 + 7) : (ADDR_W - 1);
    if (b * 8 < ADDR_W) begin : g_lane
      always_ff @(posedge aclk) begin
        if (!aresetn) begin
          addr_ff[HI:b*8] <= '0;
        end else if (wr_go && ({wr_word, 2'b00} == fwp_pkg::OFF_ADDR) && wstrb_ff[b]) begin
          addr_ff[HI:b*8] <= wdata_ff[HI:b*8];
        end
      end
    end
  end

  assign cmd_fire = wr_go && ({wr_word, 2'b00} == fwp_pkg::OFF_CMD) && wstrb_ff[0];
  assign cmd_op = wdata_ff[fwp_pkg::CMD_OP_LO +: 8];
  assign cmd_dat = wdata_ff[fwp_pkg::CMD_DAT_LO +: 8];

  fwp_prot_decode #(
    .ADDR_W(ADDR_W)
  ) u_decode (
    .code(level_code),
    .area_bottom(config_ff[fwp_pkg::CFG_AREA]),
    .big_blocks(config_ff[fwp_pkg::CFG_BIG]),
    .addr(addr_ff),
    .hit(prot_hit)
  );

  // Command evaluation
  always_comb begin
    nxt_status = status_ff;
    nxt_rdparam = rdparam_ff;
    nxt_bank = bank_ff;
    res = fwp_pkg::FWP_RES_NONE;
    grant = 1'b0;
    if (cmd_fire) begin
      res = fwp_pkg::FWP_RES_ACCEPT;
      unique case (cmd_op)
        fwp_pkg::OP_WR_EN: nxt_status[fwp_pkg::ST_WEL] = 1'b1;
        fwp_pkg::OP_WRDI: nxt_status[fwp_pkg::ST_WEL] = 1'b0;
        fwp_pkg::OP_STATUS_WR: begin
          if (!status_ff[fwp_pkg::ST_WEL]) begin
            res = fwp_pkg::FWP_RES_NO_WEL;
          end else if (status_ff[fwp_pkg::ST_LOCK] && !wp_level_ff) begin
            res = fwp_pkg::FWP_RES_LOCKED;
          end else begin
            // Only path that changes level, quad and lock bits
            nxt_status[fwp_pkg::ST_PL_LO +: 4] = cmd_dat[fwp_pkg::ST_PL_LO +: 4];
            nxt_status[fwp_pkg::ST_QUAD] = cmd_dat[fwp_pkg::ST_QUAD];
            nxt_status[fwp_pkg::ST_LOCK] = cmd_dat[fwp_pkg::ST_LOCK];
            nxt_status[fwp_pkg::ST_WEL] = 1'b0;
          end
        end
        fwp_pkg::OP_ERASE_ALL_A, fwp_pkg::OP_ERASE_ALL_B: begin
          if (!status_ff[fwp_pkg::ST_WEL]) begin
            res = fwp_pkg::FWP_RES_NO_WEL;
          end else if (level_code != 4'h0) begin
            res = fwp_pkg::FWP_RES_PROTECTED;
          end else begin
            grant = 1'b1;
            nxt_status[fwp_pkg::ST_WEL] = 1'b0;
          end
        end
        fwp_pkg::OP_RDP_V_FREE: nxt_rdparam = cmd_dat;
        fwp_pkg::OP_BANK_V_FREE: nxt_bank = cmd_dat;
        fwp_pkg::OP_RDP_V, fwp_pkg::OP_BANK_V: begin
          if (!status_ff[fwp_pkg::ST_WEL]) begin
            res = fwp_pkg::FWP_RES_NO_WEL;
          end else begin
            nxt_status[fwp_pkg::ST_WEL] = 1'b0;
            if (cmd_op == fwp_pkg::OP_RDP_V) begin
              nxt_rdparam = cmd_dat;
            end else begin
              nxt_bank = cmd_dat;
            end
          end
        end
        default: begin
          if (!is_prog_erase(cmd_op)) begin
            res = fwp_pkg::FWP_RES_UNKNOWN;
          end else if (!status_ff[fwp_pkg::ST_WEL]) begin
            res = fwp_pkg::FWP_RES_NO_WEL;
          end else if (prot_hit) begin
            res = fwp_pkg::FWP_RES_PROTECTED;
          end else begin
            grant = 1'b1;
            nxt_status[fwp_pkg::ST_WEL] = 1'b0;
          end
        end
      endcase
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      status_ff <= fwp_pkg::STATUS_RST;
      rdparam_ff <= 8'h00;
      bank_ff <= 8'h00;
    end else begin
      status_ff <= nxt_status;
      rdparam_ff <= nxt_rdparam;
      bank_ff <= nxt_bank;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      result_ff <= 16'h0000;
    end else if (cmd_fire) begin
      result_ff <= {cmd_op, 4'h0, res};
    end
  end

  // Grant is a one-cycle pulse carrying the command
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      op_valid_ff <= 1'b0;
      op_code_ff <= 8'h00;
      op_addr_ff <= '0;
    end else begin
      op_valid_ff <= grant;
      if (grant) begin
        op_code_ff <= cmd_op;
        op_addr_ff <= addr_ff;
      end
    end
  end

  assign array_op_valid = op_valid_ff;
  assign array_op_code = op_code_ff;
  assign array_op_addr = op_addr_ff;

  // Shared pins; quad mode drops the protect and hold meaning
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wp_level_ff <= 1'b1;
      hold_level_ff <= 1'b1;
      dq_in_ff <= 2'h0;
      dq_out_ff <= 2'h0;
      dq_oe_ff <= 1'b0;
    end else if (status_ff[fwp_pkg::ST_QUAD]) begin
      wp_level_ff <= 1'b1;
      hold_level_ff <= 1'b1;
      dq_in_ff <= {data_line_fourth_i, data_line_third_i};
      dq_out_ff <= core_dq_o;
      dq_oe_ff <= core_dq_oe;
    end else begin
      wp_level_ff <= data_line_third_i;
      hold_level_ff <= data_line_fourth_i;
      dq_in_ff <= 2'h0;
      dq_out_ff <= 2'h0;
      dq_oe_ff <= 1'b0;
    end
  end

  assign data_line_third_o = dq_out_ff[0];
  assign data_line_fourth_o = dq_out_ff[1];
  assign data_line_third_oe = dq_oe_ff;
  assign data_line_fourth_oe = dq_oe_ff;
  assign core_dq_i = dq_in_ff;
  assign write_protect_n = wp_level_ff;
  assign hold_reset_n = hold_level_ff;
  assign quad_mode = status_ff[fwp_pkg::ST_QUAD];

  // AXI read channel
  assign s_axi_arready = !rvalid_ff;
  assign rd_word = s_axi_araddr[7:2];
  assign s_axi_rvalid = rvalid_ff;
  assign s_axi_rdata = rdata_ff;
  assign s_axi_rresp = rresp_ff;

  always_comb begin
    nxt_rdata = 32'h0000_0000;
    nxt_rmapped = 1'b1;
    unique case ({rd_word, 2'b00})
      fwp_pkg::OFF_STATUS: nxt_rdata = {24'h00_0000, status_ff};
      fwp_pkg::OFF_CONFIG: nxt_rdata = {30'h0000_0000, config_ff};
      fwp_pkg::OFF_CMD: nxt_rdata = 32'h0000_0000;
      fwp_pkg::OFF_ADDR: nxt_rdata = 32'(addr_ff);
      fwp_pkg::OFF_RESULT: nxt_rdata = {16'h0000, result_ff};
      fwp_pkg::OFF_RDPARAM: nxt_rdata = {24'h00_0000, rdparam_ff};
      fwp_pkg::OFF_BANK: nxt_rdata = {24'h00_0000, bank_ff};
      default: nxt_rmapped = 1'b0;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_ff <= 1'b0;
      rdata_ff <= 32'h0000_0000;
      rresp_ff <= fwp_pkg::RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      rvalid_ff <= 1'b1;
      rdata_ff <= nxt_rdata;
      rresp_ff <= nxt_rmapped ? fwp_pkg::RESP_OKAY : fwp_pkg::RESP_SLVERR;
    end else if (s_axi_rready) begin
      rvalid_ff <= 1'b0;
    end
  end
endmodule // fwp_top
`default_nettype wire
